// ==== rtl/owd_pkg.sv ====
// Operation
// - Sync precedes each instruction; once after repeat.
// - Count port cycles spanning 8-bit sync.
// - Programmer pulls pin low over 200 ns.
// - Edge detector holds pin low until oscillator ready.
// - Programmer polls high before sending sync.
// - Enabling sync enables port; no extra sync.
// - Low hold is 256 oscillator cycles plus calibration.
// - Debug fuse makes reset pin pulled-up input.
// - Sync 0x55 must start before maximum delay.
// - High-voltage pulse forces debug, holds port reset.
// - Key follows first sync after high voltage.
// - Debugger ends session with port disable bit.
// - High-voltage pulse 100 us to 1 ms.
// - Only power-on reset undoes high-voltage takeover.
// - GPIO driver off 8.8 ms after reset.
// - Disable if no sync within 65536 cycles.
// - Start-up disable withdraws all power requests.
// - Reject sync on overflow or too short.
// - Frame: start, eight data, even parity, two stops.
// - Sync length held in 16-bit counter.
// - Port disable resets system, drops clock, clears keys.
package owd_pkg;
    localparam int          CLK_HZ          = 40000000;
    localparam int          PULSE_NS        = 200;
    localparam int          PULSE_CYC       = (PULSE_NS * 40 + 999) / 1000 + 1;
    localparam int          OSC_CYC         = 256;
    localparam int          CAL_CYC         = 16;
    localparam int          SYNC_TMO_CYC    = 65536;
    localparam int          GPIO_BLANK_US10 = 88;
    localparam int          GPIO_BLANK_CYC  = GPIO_BLANK_US10 * 4000;
    localparam int          HV_MIN_US       = 100;
    localparam int          HV_CYC          = HV_MIN_US * (CLK_HZ / 1000000);
    localparam int          CNT_W           = 16;
    localparam int          MIN_SYNC_CYC    = 32;
    localparam logic [7:0]  SYNC_CHAR       = 8'h55;
    localparam logic [7:0]  KEY_INSTR       = 8'he0;
    localparam logic [7:0]  CONTROL_STATUS_STORE_INSTRUCTION_CTRLB      = 8'hc3;
    localparam logic [7:0]  CTRLB_DISABLE   = 8'h04;
    localparam int          BIT_CYC         = 64;
    typedef enum logic [2:0] {
        OWD_OFF, OWD_HOLD, OWD_WAIT, OWD_MEAS, OWD_ON
    } owd_state_t;
endpackage : owd_pkg

// ==== rtl/owd_if.sv ====
`timescale 1ns/1ps
// One-wire debug pin plus the out-of-band high-voltage and power-on lines.
interface owd_if;
    logic dev_o;
    logic dev_oe;
    logic prg_o;
    logic prg_oe;
    logic hv_pulse;
    logic por;
    wire  line_lvl = !((dev_oe && !dev_o) || (prg_oe && !prg_o));
    modport device (output dev_o, dev_oe, input line_lvl, hv_pulse, por);
    modport host (output prg_o, prg_oe, hv_pulse, por, input line_lvl);
endinterface : owd_if

// ==== rtl/owd_fifo.sv ====
`timescale 1ns/1ps
// Byte FIFO between host user side and its serialiser.
module owd_fifo #(
    parameter int W = 8,
    parameter int D = 32
) (
    input  wire logic         clock,
    input  wire logic         sys_rst,
    input  wire logic [W-1:0] in_data,
    input  wire logic         in_valid,
    output logic              in_ready,
    output logic [W-1:0]      out_data,
    output logic              out_valid,
    input  wire logic         out_ready
);
    localparam int AW = $clog2(D);
    logic [W-1:0]  mem [D];
    logic [AW:0]   wp_q, wp_d, rp_q, rp_d;
    logic          push, pop;
    // Pointers carry a wrap bit so full and empty are exact.
    always_comb begin
        in_ready  = (wp_q - rp_q) != (AW+1)'(D);
        out_valid = wp_q != rp_q;
        push      = in_valid && in_ready;
        pop       = out_valid && out_ready;
        wp_d      = wp_q + (AW+1)'(push);
        rp_d      = rp_q + (AW+1)'(pop);
        out_data  = mem[rp_q[AW-1:0]];
    end
    // Register pointers and the written word.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            wp_q <= '0;
            rp_q <= '0;
        end else begin
            wp_q <= wp_d;
            rp_q <= rp_d;
        end
        if (push) begin
            mem[wp_q[AW-1:0]] <= in_data;
        end
    end
endmodule : owd_fifo

// ==== rtl/owd_dev.sv ====
`timescale 1ns/1ps
// Device end: wake-up edge detector, sync measurement, self-disable.
module owd_dev import owd_pkg::*; #(
    parameter int TMO_CYC   = SYNC_TMO_CYC,
    parameter int BLANK_CYC = GPIO_BLANK_CYC
) (
    input  wire logic         clock,
    input  wire logic         sys_rst,
    owd_if.device             pin,
    input  wire logic         reset_pin_function_fuse,
    input  wire logic         port_disable_bit,
    output logic              port_enabled,
    output logic              clk_request,
    output logic              pin_debug_mode,
    output logic              gpio_oe_allow,
    output logic [CNT_W-1:0]  sync_count,
    output logic              sync_valid,
    output logic              sys_reset_req,
    output logic              keys_clear
);
    logic [1:0]       ls_q, hs_q, ps_q;
    logic             lvl, lvl_prev_q, hv, hv_prev_q, por;
    owd_state_t       st_q, st_d;
    logic [16:0]      cnt_q, cnt_d;
    logic [3:0]       edg_q, edg_d;
    logic [CNT_W-1:0] sc_q, sc_d;
    logic             sv_q, sv_d, hvm_q, hvm_d, hvr_q, hvr_d;
    logic [18:0]      blk_q, blk_d;
    logic             fall, rise;
    // Two-stage synchronisers for pins from outside the clock domain.
    always_ff @(posedge clock) begin
        ls_q       <= {ls_q[0], pin.line_lvl};
        hs_q       <= {hs_q[0], pin.hv_pulse};
        ps_q       <= {ps_q[0], pin.por};
        lvl_prev_q <= lvl;
        hv_prev_q  <= hv;
    end
    assign lvl  = ls_q[1];
    assign hv   = hs_q[1];
    assign por  = ps_q[1];
    assign fall = lvl_prev_q && !lvl;
    assign rise = !lvl_prev_q && lvl;
    // Start-up sequence, sync measurement and self-disable.
    always_comb begin
        st_d  = st_q;
        cnt_d = cnt_q;
        edg_d = edg_q;
        sc_d  = sc_q;
        sv_d  = sv_q;
        hvm_d = hvm_q;
        hvr_d = hvr_q;
        blk_d = (blk_q == 19'(BLANK_CYC)) ? blk_q : blk_q + 19'h1;
        if (hv && !hv_prev_q) begin
            hvm_d = 1'b1;
            hvr_d = 1'b1;
        end
        if (por) begin
            hvm_d = 1'b0;
        end
        unique case (st_q)
            OWD_OFF: begin
                cnt_d = '0;
                sv_d  = 1'b0;
                if (hvr_q && !hv && fall) begin
                    hvr_d = 1'b0;
                end
                if (fall && !(hvr_q && hv) &&
                    (reset_pin_function_fuse || hvm_q)) begin
                    st_d = OWD_HOLD;
                end
            end
            OWD_HOLD: begin
                cnt_d = cnt_q + 17'h1;
                if (cnt_q == 17'(OSC_CYC + CAL_CYC)) begin
                    st_d  = OWD_WAIT;
                    cnt_d = '0;
                end
            end
            OWD_WAIT: begin
                cnt_d = cnt_q + 17'h1;
                if (fall && cnt_q > 17'h2) begin
                    st_d  = OWD_MEAS;
                    cnt_d = '0;
                    edg_d = '0;
                end else if (cnt_q == 17'(TMO_CYC - 1)) begin
                    st_d = OWD_OFF;
                end
            end
            OWD_MEAS: begin
                cnt_d = cnt_q + 17'h1;
                if (fall || rise) begin
                    edg_d = edg_q + 4'h1;
                end
                // The eighth toggle after the start edge ends the pattern.
                if (cnt_q[16]) begin
                    st_d = OWD_OFF;
                end else if ((fall || rise) && edg_q == 4'h7) begin
                    if (cnt_q < 17'(MIN_SYNC_CYC)) begin
                        st_d = OWD_OFF;
                    end else begin
                        st_d = OWD_ON;
                        sc_d = cnt_q[CNT_W-1:0];
                        sv_d = 1'b1;
                    end
                end
            end
            OWD_ON: begin
                if (port_disable_bit) begin
                    st_d = OWD_OFF;
                end
            end
            default: st_d = OWD_OFF;
        endcase
        if (hv && !hv_prev_q) begin
            st_d = OWD_OFF;
        end
    end
    // State registers; high-voltage mode survives everything but power-on.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            st_q  <= OWD_OFF;
            cnt_q <= '0;
            edg_q <= '0;
            sc_q  <= '0;
            sv_q  <= 1'b0;
            blk_q <= '0;
        end else begin
            st_q  <= st_d;
            cnt_q <= cnt_d;
            edg_q <= edg_d;
            sc_q  <= sc_d;
            sv_q  <= sv_d;
            blk_q <= blk_d;
        end
        hvm_q <= hvm_d;
        hvr_q <= hvr_d;
        if (sys_rst && por) begin
            hvm_q <= 1'b0;
            hvr_q <= 1'b0;
        end
    end
    // Pin drive: only the edge detector drives, and only low.
    assign pin.dev_o      = 1'b0;
    assign pin.dev_oe     = (st_q == OWD_HOLD);
    assign port_enabled   = (st_q == OWD_ON);
    assign clk_request    = (st_q != OWD_OFF);
    assign pin_debug_mode = reset_pin_function_fuse || hvm_q;
    assign gpio_oe_allow  = !pin_debug_mode && (blk_q == 19'(BLANK_CYC));
    assign sync_count     = sc_q;
    assign sync_valid     = sv_q;
    assign sys_reset_req  = port_enabled && port_disable_bit;
    assign keys_clear     = sys_reset_req;
endmodule : owd_dev

// ==== rtl/owd_host.sv ====
`timescale 1ns/1ps
// Programmer end: wake pulse, poll high, then stream framed bytes.
module owd_host import owd_pkg::*; (
    input  wire logic       clock,
    input  wire logic       sys_rst,
    owd_if.host             pin,
    input  wire logic       start,
    input  wire logic       hv_start,
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_valid,
    output logic            tx_ready,
    output logic            busy
);
    typedef enum logic [2:0] {
        HS_IDLE, HS_HV, HS_LOW, HS_POLL, HS_SEND
    } owd_hst_t;
    owd_hst_t    st_q, st_d;
    logic [1:0]  ls_q;
    logic [15:0] t_q, t_d;
    logic [11:0] sh_q, sh_d;
    logic [3:0]  n_q, n_d;
    logic        sy_q, sy_d;
    logic [7:0]  f_data;
    logic        f_valid, f_pop;
    owd_fifo #(.W(8), .D(32)) u_fifo (
        .clock     (clock),
        .sys_rst   (sys_rst),
        .in_data   (tx_data),
        .in_valid  (tx_valid),
        .in_ready  (tx_ready),
        .out_data  (f_data),
        .out_valid (f_valid),
        .out_ready (f_pop)
    );
    // Line level synchroniser.
    always_ff @(posedge clock) begin
        ls_q <= {ls_q[0], pin.line_lvl};
    end
    // Sequencer: sync first, then the key after high voltage, then bytes.
    always_comb begin
        st_d  = st_q;
        t_d   = t_q + 16'h1;
        sh_d  = sh_q;
        n_d   = n_q;
        sy_d  = sy_q;
        f_pop = 1'b0;
        unique case (st_q)
            HS_IDLE: begin
                t_d = '0;
                if (hv_start) begin
                    st_d = HS_HV;
                    sy_d = 1'b1;
                end else if (start) begin
                    st_d = HS_LOW;
                end
            end
            HS_HV: begin
                if (t_q == 16'(HV_CYC)) begin
                    st_d = HS_LOW;
                    t_d  = '0;
                end
            end
            HS_LOW: begin
                if (t_q == 16'(PULSE_CYC)) begin
                    st_d = HS_POLL;
                    t_d  = '0;
                end
            end
            HS_POLL: begin
                if (ls_q[1] && t_q > 16'h4) begin
                    st_d = HS_SEND;
                    sh_d = {2'b11, 1'b0, SYNC_CHAR, 1'b0};
                    n_d  = 4'd12;
                    t_d  = '0;
                end
            end
            HS_SEND: begin
                if (t_q == 16'(BIT_CYC - 1)) begin
                    t_d  = '0;
                    sh_d = {1'b1, sh_q[11:1]};
                    n_d  = n_q - 4'h1;
                    if (n_q == 4'h1) begin
                        if (sy_q) begin
                            sy_d = 1'b0;
                            sh_d = {2'b11, ^KEY_INSTR, KEY_INSTR, 1'b0};
                            n_d  = 4'd12;
                        end else if (f_valid) begin
                            f_pop = 1'b1;
                            sh_d  = {2'b11, ^f_data, f_data, 1'b0};
                            n_d   = 4'd12;
                        end else begin
                            st_d = HS_IDLE;
                        end
                    end
                end
            end
            default: st_d = HS_IDLE;
        endcase
    end
    // Sequencer registers.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            st_q <= HS_IDLE;
            t_q  <= '0;
            sh_q <= '1;
            n_q  <= '0;
            sy_q <= 1'b0;
        end else begin
            st_q <= st_d;
            t_q  <= t_d;
            sh_q <= sh_d;
            n_q  <= n_d;
            sy_q <= sy_d;
        end
    end
    assign pin.prg_o    = (st_q == HS_SEND) ? sh_q[0] : 1'b0;
    assign pin.prg_oe   = (st_q == HS_LOW) || (st_q == HS_SEND && !sh_q[0]);
    assign pin.hv_pulse = (st_q == HS_HV);
    assign pin.por      = sys_rst; // Own reset doubles as power-on.
    assign busy         = (st_q != HS_IDLE);
endmodule : owd_host

// ==== tb/owd_assertions.sv ====
`timescale 1ns/1ps
// Watches the wire between the ends and the device's status outputs.
module owd_assertions import owd_pkg::*; #(
    parameter int BLANK_CYC = GPIO_BLANK_CYC
) (
    input wire logic             clock,
    input wire logic             sys_rst,
    input wire logic             dev_o,
    input wire logic             dev_oe,
    input wire logic             line_lvl,
    input wire logic             reset_pin_function_fuse,
    input wire logic             port_disable_bit,
    input wire logic             port_enabled,
    input wire logic             clk_request,
    input wire logic             pin_debug_mode,
    input wire logic             gpio_oe_allow,
    input wire logic [CNT_W-1:0] sync_count,
    input wire logic             sync_valid,
    input wire logic             sys_reset_req,
    input wire logic             keys_clear
);
    localparam int HOLD = OSC_CYC + CAL_CYC + 1;
    logic [8:0]  hold_q;
    logic [8:0]  hold_d;
    logic [31:0] up_q;
    logic [31:0] up_d;

    // Length of the current low drive and cycles since reset.
    always_comb begin
        hold_d = dev_oe ? hold_q + 9'h001 : 9'h000;
        up_d   = up_q + {31'h0, !up_q[31]};
    end

    // Registers the helper counts.
    always_ff @(posedge clock) begin
        hold_q <= sys_rst ? 9'h000 : hold_d;
        up_q   <= sys_rst ? 32'h0 : up_d;
    end

    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);

    hold_len_a: assert property (
        $fell(dev_oe) |-> hold_q == HOLD) else $error("hold length");
    low_only_a: assert property (
        dev_oe |-> !dev_o) else $error("device drives high");
    wake_hold_a: assert property (
        $fell(line_lvl) && !clk_request && pin_debug_mode |-> ##[1:5] dev_oe)
        else $error("no wake hold");
    sync_min_a: assert property (
        $rose(port_enabled) |-> sync_count >= MIN_SYNC_CYC)
        else $error("short sync accepted");
    enabled_clk_a: assert property (
        port_enabled |-> clk_request) else $error("enabled without clock");
    reset_req_a: assert property (
        sys_reset_req == (port_enabled && port_disable_bit))
        else $error("reset request");
    keys_clear_a: assert property (
        keys_clear == sys_reset_req) else $error("keys clear");
    disable_off_a: assert property (
        port_enabled && port_disable_bit |-> ##[1:4] !port_enabled && !clk_request)
        else $error("not disabled");
    gpio_blank_a: assert property (
        gpio_oe_allow |-> up_q >= BLANK_CYC - 1) else $error("gpio early");
    debug_keep_a: assert property (
        pin_debug_mode && $stable(reset_pin_function_fuse) |=> pin_debug_mode)
        else $error("debug mode lost");

    enable_c: cover property ($rose(port_enabled));
    hold_c: cover property ($fell(dev_oe));
    sync_c: cover property (sync_valid);
endmodule : owd_assertions

// ==== tb/one_wire_debug_enable_sync_bench.sv ====
`timescale 1ns/1ps
// Both ends on one wire, a scripted programmer on a second wire.
module one_wire_debug_enable_sync_bench import owd_pkg::*;;
    localparam int TMO = 2000;
    localparam int BLK = 100;
    logic        clock = 1'b0;
    logic        sys_rst = 1'b1;
    logic        dis = 1'b0;
    logic        dis_b = 1'b0;
    logic        start = 1'b0;
    logic        hv_start = 1'b0;
    logic        tx_valid = 1'b0;
    logic [7:0]  tx_data = 8'h00;
    logic [31:0] rng = 32'h3f;
    int          err_total = 0;
    int          comparisons = 0;
    int          k;
    int          n;
    logic        en, en_b, ck, ck_b, dbg, dbg_b, gp, gp_b, srq, kcl, sv, sv_b;
    logic        tx_ready, busy;
    logic [15:0] scnt, scnt_b;
    owd_if w ();
    owd_if wb ();

    owd_dev #(.TMO_CYC(TMO), .BLANK_CYC(BLK)) u_owd_dev (
        .clock(clock), .sys_rst(sys_rst), .pin(w.device),
        .reset_pin_function_fuse(1'b1), .port_disable_bit(dis),
        .port_enabled(en), .clk_request(ck), .pin_debug_mode(dbg),
        .gpio_oe_allow(gp), .sync_count(scnt), .sync_valid(sv),
        .sys_reset_req(srq), .keys_clear(kcl));
    owd_host u_owd_host (
        .clock(clock), .sys_rst(sys_rst), .pin(w.host), .start(start),
        .hv_start(hv_start), .tx_data(tx_data), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .busy(busy));
    owd_dev #(.TMO_CYC(TMO), .BLANK_CYC(BLK)) u_owd_dev_b (
        .clock(clock), .sys_rst(sys_rst), .pin(wb.device),
        .reset_pin_function_fuse(1'b0), .port_disable_bit(dis_b),
        .port_enabled(en_b), .clk_request(ck_b), .pin_debug_mode(dbg_b),
        .gpio_oe_allow(gp_b), .sync_count(scnt_b), .sync_valid(sv_b),
        .sys_reset_req(), .keys_clear());
    owd_assertions #(.BLANK_CYC(BLK)) u_owd_assertions (
        .clock(clock), .sys_rst(sys_rst), .dev_o(w.dev_o),
        .dev_oe(w.dev_oe), .line_lvl(w.line_lvl),
        .reset_pin_function_fuse(1'b1), .port_disable_bit(dis),
        .port_enabled(en), .clk_request(ck), .pin_debug_mode(dbg),
        .gpio_oe_allow(gp), .sync_count(scnt), .sync_valid(sv),
        .sys_reset_req(srq), .keys_clear(kcl));

    // Free-running 40 MHz clock.
    always #12.5 clock = ~clock;

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs

    task automatic cyc(input int c);
        repeat (c) @(negedge clock);
    endtask : cyc

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s: expected %0h seen %0h", nm, e, g);
        end
    endtask : chk

    // Low pulse from the scripted programmer, then poll for high.
    task automatic wake_b(input int c, input logic hold);
        wb.prg_oe = 1'b1;
        cyc(c);
        wb.prg_oe = 1'b0;
        chk("hold", hold, wb.dev_oe);
        k = 0;
        while (wb.line_lvl !== 1'b1 && k < 400) begin
            cyc(1);
            k++;
        end
        chk("line_high", 1, wb.line_lvl);
        cyc(4);
    endtask : wake_b

    // One frame, LSB first, open-drain onto the pulled-up wire.
    task automatic frame_b(input logic [7:0] b, input int bc);
        logic [11:0] f;
        f = {2'b11, ^b, b, 1'b0};
        for (int i = 0; i < 12; i++) begin
            wb.prg_oe = !f[i];
            cyc(bc);
        end
    endtask : frame_b

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : close_out

    // Main sequence.
    initial begin
        wb.prg_o = 1'b0;
        wb.prg_oe = 1'b0;
        wb.hv_pulse = 1'b0;
        wb.por = 1'b1;
        cyc(8);
        sys_rst = 1'b0;
        wb.por = 1'b0;
        cyc(2);
        chk("debug_mode", 1, dbg);
        chk("gpio_blank", 0, gp_b);
        n = 0;
        tx_valid = 1'b1;
        repeat (40) begin
            rng = xs(rng);
            tx_data = rng[7:0];
            n += int'(tx_ready);
            cyc(1);
        end
        tx_valid = 1'b0;
        chk("fifo_depth", 32, n);
        start = 1'b1;
        cyc(1);
        start = 1'b0;
        k = 0;
        while (en !== 1'b1 && k < 3000) begin
            cyc(1);
            k++;
        end
        chk("enabled", 1, en);
        chk("sync_len", 1, scnt >= 8 * BIT_CYC - 8 && scnt <= 8 * BIT_CYC + 8);
        // The host drains its queue while the scripted wire is exercised.
        wake_b(12, 1'b0);
        wb.hv_pulse = 1'b1;
        cyc(HV_CYC);
        wb.hv_pulse = 1'b0;
        cyc(4);
        chk("hv_mode", 1, dbg_b);
        wake_b(10, 1'b1);
        cyc(TMO + 50);
        chk("timeout_en", 0, en_b);
        chk("timeout_clk", 0, ck_b);
        // Too short, overflowing, then a good sync length.
        for (int i = 0; i < 3; i++) begin
            wake_b(10 + int'(rng[3:0]), 1'b1);
            rng = xs(rng);
            if (i == 1) begin
                wb.prg_oe = 1'b1;
                cyc(65600);
                wb.prg_oe = 1'b0;
            end else begin
                frame_b(SYNC_CHAR, i == 0 ? 2 : BIT_CYC);
            end
            cyc(8);
            chk("sync_result", i == 2, en_b);
            chk("sync_clk", i == 2, ck_b);
        end
        dis_b = 1'b1;
        cyc(5);
        dis_b = 1'b0;
        chk("hv_kept", 1, dbg_b);
        k = 0;
        while (busy !== 1'b0 && k < 30000) begin
            cyc(1);
            k++;
        end
        chk("drained", 0, busy);
        chk("idle_high", 1, w.line_lvl);
        dis = 1'b1;
        #1;
        chk("reset_req", 1, srq);
        chk("keys_clear", 1, kcl);
        cyc(5);
        dis = 1'b0;
        chk("disabled", 0, en);
        chk("clk_drop", 0, ck);
        // High-voltage start of the host; the key frame follows the sync.
        hv_start = 1'b1;
        cyc(1);
        hv_start = 1'b0;
        k = 0;
        while (en !== 1'b1 && k < 6000) begin
            cyc(1);
            k++;
        end
        chk("hv_enable", 1, en);
        k = 0;
        while (busy !== 1'b0 && k < 2000) begin
            cyc(1);
            k++;
        end
        chk("key_sent", 0, busy);
        // A system reset in mid-run must leave high-voltage mode in place.
        sys_rst = 1'b1;
        cyc(4);
        sys_rst = 1'b0;
        cyc(2);
        chk("hv_rst_kept", 1, dbg_b);
        wb.por = 1'b1;
        cyc(3);
        wb.por = 1'b0;
        cyc(3);
        chk("por_clear", 0, dbg_b);
        chk("gpio_reblank", 0, gp_b);
        cyc(BLK);
        chk("gpio_allow", 1, gp_b);
        close_out();
    end

    // Cuts a hang short.
    initial begin
        #(25 * 90000);
        err_total++;
        close_out();
    end
endmodule : one_wire_debug_enable_sync_bench
